// ===== bench/handler_judgment_io_properties.sv
// Checker: bus answer and handler pin timing of the judgment block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
module handler_judgment_io_properties
   import handler_io_pkg::*;
(
   // Watched ports
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic measure_done_n,
   input wire logic conversion_done_n,
   input wire logic error_n,
   input wire logic [JUDGE_WIDTH-1:0] judge_n,
   input wire logic [3:0] bin_extra_n,
   input wire logic no_bin_match_n,
   input wire logic sub_fail_n
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   logic [JUDGE_WIDTH+6:0] outs;
   assign outs = {judge_n, bin_extra_n, no_bin_match_n, sub_fail_n, error_n};
   sequence s_take(logic w, logic [7:0] a);
      hsel && hready && htrans == HTRANS_NONSEQ && hwrite == w && haddr == a;
   endsequence
   sequence s_cmd(int b);
      s_take(1'b1, STATUS_OFS) ##1 hwdata[b];
   endsequence
   property p_okay;
      hreadyout && !hresp;
   endproperty
   property p_unmapped;
      hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr > PANEL_OFS && haddr[1:0] == 2'h0
         |=> hrdata == 32'h0;
   endproperty
   property p_adcDone;
      s_cmd(CMD_ADC_DONE_BIT) |-> ##[0:2] !conversion_done_n;
   endproperty
   property p_publishHold;
      s_cmd(CMD_PUBLISH_BIT) |-> measure_done_n [*4];
   endproperty
   property p_publishDone;
      s_cmd(CMD_PUBLISH_BIT) |-> ##[4:9] !measure_done_n;
   endproperty
   property p_heldFinal;
      !measure_done_n |-> $stable(outs);
   endproperty
   property p_settled;
      $fell(measure_done_n) |-> outs == $past(outs, 4);
   endproperty
   property p_order;
      $fell(measure_done_n) |-> !conversion_done_n;
   endproperty
   a_okay: assert property (p_okay) else $error("bus answer not ready and okay");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_adcDone: assert property (p_adcDone) else $error("conversion done did not fall");
   a_publishHold: assert property (p_publishHold) else $error("completion too early");
   a_publishDone: assert property (p_publishDone) else $error("completion missing");
   a_heldFinal: assert property (p_heldFinal) else $error("outputs moved while final");
   a_settled: assert property (p_settled) else $error("outputs unsettled at completion");
   a_order: assert property (p_order) else $error("completion before conversion");
endmodule

bind handler_judgment_io handler_judgment_io_properties u_props (.sys_clk, .reset_n, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .measure_done_n, .conversion_done_n,
   .error_n, .judge_n, .bin_extra_n, .no_bin_match_n, .sub_fail_n);

// ===== bench/handler_judgment_io_test.sv
// Testbench: bus registers, trigger, conversion, completion and panel load.
// Assumes the handler model on the pin side and this module as bus master.
`timescale 1ns/1ps
module handler_judgment_io_test
   import handler_io_pkg::*;
;
   logic sys_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rdv;
   logic measure_trigger, panel_load_strobe_n, measure_done_n, conversion_done_n;
   logic error_n, no_bin_match_n, sub_fail_n;
   logic [6:0] panel_sel_n, num;
   logic [JUDGE_WIDTH-1:0] judge_n, ej;
   logic [3:0] bin_extra_n;
   logic [15:0] res;
   logic [4:0] errs;
   int error_cnt, compares, cyc;
   assign hready = hreadyout;
   handler_judgment_io u_dut (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
      .hrdata, .hreadyout, .hresp, .irq, .measure_trigger, .panel_sel_n, .panel_load_strobe_n, .measure_done_n,
      .conversion_done_n, .error_n, .judge_n, .bin_extra_n, .no_bin_match_n, .sub_fail_n);
   handler_model u_handler (.sys_clk, .measure_trigger, .panel_sel_n, .panel_load_strobe_n, .conversion_done_n);
   function automatic logic [1:0] expBin(input logic [15:0] r);
      return {~r[10], ~r[11]};
   endfunction
   // Judgment lines per mode: 0 LCR comparator, 1 LCR bins, 2 continuous
   function automatic logic [JUDGE_WIDTH-1:0] expJudge(input logic [15:0] r, input int m);
      logic [JUDGE_WIDTH-1:0] j;
      j = '0;
      if (m == 2) j[5:0] = {r[5], r[4], r[14] & r[15] & ~r[10], r[2], r[1], r[0]};
      else if (m == 1) j[9:0] = r[9:0];
      else j[5:0] = r[5:0];
      return ~j;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Single transfer; waits on hready, never on a fixed count
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      q = hrdata;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      #200us;
      error_cnt++;
      print_verdict();
   end
   initial begin
      reset_n = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      error_cnt = 0;
      compares = 0;
      void'($urandom(32'h5153));
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      bus(1'b0, CTRL_OFS, 32'h0, rdv);
      check(rdv, CTRL_RESET);
      check({measure_done_n, conversion_done_n, error_n, no_bin_match_n, sub_fail_n, irq}, 6'h3e);
      bus(1'b1, 8'h1c, 32'hffff_ffff, rdv);
      bus(1'b0, 8'h1c, 32'h0, rdv);
      check(rdv, 32'h0);
      bus(1'b1, IRQ_MASK_OFS, 32'h7, rdv);
      $display("test reset finished");
      for (int i = 0; i < 6; i++) begin
         res = (i == 0) ? 16'hffff : 16'($urandom);
         errs = (i == 1) ? 5'h0 : 5'($urandom_range(31, 1));
         bus(1'b1, CTRL_OFS, {28'h0, i % 3 == 1, i % 3 == 2, i[0], 1'b0}, rdv);
         u_handler.toggle(3);
         u_handler.toggle(3);
         if (measure_trigger !== !i[0]) u_handler.toggle(3);
         bus(1'b0, IRQ_STAT_OFS, 32'h0, rdv);
         check(rdv[IRQ_MEASURE_TRIGGER_BIT], 1'b0);
         bus(1'b1, RESULT_OFS, 32'(res), rdv);
         bus(1'b1, ERRSRC_OFS, 32'(errs), rdv);
         bus(1'b1, CTRL_OFS, {28'h0, i % 3 == 1, i % 3 == 2, i[0], 1'b1}, rdv);
         u_handler.toggle(5);
         check(irq, 1'b1);
         bus(1'b1, STATUS_OFS, 32'h1 << CMD_ADC_DONE_BIT, rdv);
         u_handler.swapSample();
         check(conversion_done_n, 1'b0);
         check(u_handler.swaps, i + 1);
         bus(1'b1, STATUS_OFS, 32'h1 << CMD_PUBLISH_BIT, rdv);
         for (cyc = 0; cyc < 50 && measure_done_n !== 1'b0; cyc++) @(posedge sys_clk);
         check({measure_done_n, cyc >= SETTLE_CYCLES}, 2'b01);
         check(error_n, errs == 5'h0);
         if (i % 3 == 1) check({no_bin_match_n, sub_fail_n}, expBin(res));
         else check({no_bin_match_n, sub_fail_n}, 2'b11);
         ej = expJudge(res, i % 3);
         check(judge_n[5:0], ej[5:0]);
         if (i % 3 != 2) check(judge_n[11:6], ej[11:6]);
         check(bin_extra_n, {2'b11, ~res[13:12]});
         bus(1'b1, IRQ_STAT_OFS, 32'h7, rdv);
         bus(1'b0, IRQ_STAT_OFS, 32'h0, rdv);
         check(rdv, 32'h0);
         check(irq, 1'b0);
         $display("test measure %0d finished", i);
      end
      // Falling edge during settling: dropped unless enabled, then kept
      for (int j = 0; j < 2; j++) begin
         bus(1'b1, CTRL_OFS, 32'h1 | (32'(j) << CTRL_MEASURE_TRIGGER_BUSY_EN_BIT), rdv);
         if (measure_trigger !== 1'b1) u_handler.toggle(2);
         u_handler.toggle(2);
         bus(1'b1, STATUS_OFS, 32'h1 << CMD_PUBLISH_BIT, rdv);
         u_handler.toggle(1);
         u_handler.toggle(1);
         repeat (8) @(posedge sys_clk);
         check(measure_done_n, j == 1);
         $display("test busy trigger %0d finished", j);
      end
      bus(1'b1, IRQ_MASK_OFS, 32'h0, rdv);
      for (int i = 0; i < 3; i++) begin
         num = (i == 0) ? 7'h7f : 7'($urandom);
         u_handler.loadPanel(num, i + 1);
         bus(1'b0, PANEL_OFS, 32'h0, rdv);
         check(rdv, 32'(num));
         bus(1'b0, IRQ_STAT_OFS, 32'h0, rdv);
         check({irq, rdv[IRQ_PANEL_BIT]}, 2'b01);
         bus(1'b1, IRQ_STAT_OFS, 32'h7, rdv);
         $display("test panel %0d finished", i);
      end
      print_verdict();
   end
endmodule

// ===== bench/handler_model.sv
// Handler model: trigger line, panel select and load strobe, sample swap.
// Assumes each task is entered just after a rising edge of sys_clk.
`timescale 1ns/1ps
module handler_model
(
   // Clock
   input wire logic sys_clk,
   // Pins to and from the block
   output logic measure_trigger,
   output logic [6:0] panel_sel_n,
   output logic panel_load_strobe_n,
   input wire logic conversion_done_n
);
   int swaps;
   initial begin
      measure_trigger = 1'b1;
      panel_sel_n = 7'h7f;
      panel_load_strobe_n = 1'b1;
      swaps = 0;
   end
   // One edge per call; the block decides whether it counts
   task automatic toggle(input int gap);
      measure_trigger <= ~measure_trigger;
      repeat (gap) @(posedge sys_clk);
   endtask
   // Swap only once conversion is reported done
   task automatic swapSample();
      for (int c = 0; c < 20 && conversion_done_n !== 1'b0; c++) @(posedge sys_clk);
      if (conversion_done_n === 1'b0) swaps++;
   endtask
   // Select held before and through the strobe; inverted once released
   task automatic loadPanel(input logic [6:0] num, input int hold);
      panel_sel_n <= ~num;
      repeat (hold) @(posedge sys_clk);
      panel_load_strobe_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      panel_load_strobe_n <= 1'b1;
      @(posedge sys_clk);
      panel_sel_n <= num;
      repeat (2) @(posedge sys_clk);
   endtask
endmodule

// ===== rtl/edge_detect.sv
// Edge detector for the trigger pin, selectable polarity.
// Assumes the input is synchronous to sys_clk.
`timescale 1ns/1ps
module edge_detect
(
   // Clock and reset
   input wire logic sysClk,
   input wire logic rstN,
   // Level in, edge out
   input wire logic levelIn,
   input wire logic risingSel,
   output logic edgeOut
);
   logic prev_reg;

   always_ff @(posedge sysClk or negedge rstN) begin
      if (!rstN) begin
         prev_reg <= 1'b1;
      end else begin
         prev_reg <= levelIn;
      end
   end

   assign edgeOut = risingSel ? (levelIn & ~prev_reg) : (~levelIn & prev_reg);
endmodule

// ===== rtl/handler_io_pkg.sv
// Package: constants shared by the handler judgment I/O block.
// Assumes a 50 MHz system clock and an AHB-Lite register bus with 32-bit data.
package handler_io_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] RESULT_OFS = 8'h04;
   localparam logic [7:0] ERRSRC_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
   localparam logic [7:0] PANEL_OFS = 8'h18;
   // Control fields
   localparam int CTRL_EXT_MEASURE_TRIGGER_BIT = 0;
   localparam int CTRL_RISING_BIT = 1;
   localparam int CTRL_CONT_MODE_BIT = 2;
   localparam int CTRL_BIN_JUDGE_BIT = 3;
   localparam int CTRL_MEASURE_TRIGGER_BUSY_EN_BIT = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   // Command (write-only) fields in the status word
   localparam int CMD_ADC_DONE_BIT = 0;
   localparam int CMD_PUBLISH_BIT = 1;
   // Interrupt status bits
   localparam int IRQ_MEASURE_TRIGGER_BIT = 0;
   localparam int IRQ_PANEL_BIT = 1;
   localparam int IRQ_DONE_BIT = 2;
   localparam int IRQ_WIDTH = 3;
   // Error source count
   localparam int ERR_SRC_WIDTH = 5;
   // Result field width: bins 1..10, no-bin, sub-fail and comparator lines
   localparam int RESULT_WIDTH = 16;
   // Judgment output count
   localparam int JUDGE_WIDTH = 12;
   // Settle time before completion, ns, and derived cycles
   localparam int SETTLE_NS = 100;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ===== rtl/handler_judgment_io.sv
// Handler judgment I/O: isolated handler pins plus AHB-Lite register file.
// Assumes the measurement firmware writes results over the bus and the
// handler drives trigger and panel-load lines synchronously to sys_clk.
//
// Summary of operation
// - Completion low only after all judgment outputs hold their final values.
// - Conversion-done falls when conversion finishes; sample swap allowed afterwards.
// - Error output low on any of five error sources.
// - Continuous mode: overall pass only when all panels in range and bins matched.
// - LCR: shared line gives bin two or main in-range per judgment kind.
// - LCR: shared lines give bins four/six or sub high/low.
// - LCR bin judgment: dedicated line for no bin matched.
// - LCR bin judgment: dedicated line for sub-parameter failure.
// - Continuous: panel one main high, main low, sub in-range lines.
// - Continuous: panel two main in-range and sub high lines.
// - External trigger: one measurement per selected edge taken while idle, or one for any edges taken while settling if enabled; ignored when internal.
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module handler_judgment_io
   import handler_io_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   // Handler inputs
   input wire logic measure_trigger,
   input wire logic [6:0] panel_sel_n,
   input wire logic panel_load_strobe_n,
   // Handler outputs
   output logic measure_done_n,
   output logic conversion_done_n,
   output logic error_n,
   output logic [JUDGE_WIDTH-1:0] judge_n,
   output logic [3:0] bin_extra_n,
   output logic no_bin_match_n,
   output logic sub_fail_n
);
   typedef enum logic [1:0] {IDLE_S, MEASURE_S, SETTLE_S} meas_state_t;

   logic rstMeta_reg;
   logic rst_reg;
   logic rstN;
   logic [31:0] ctrl_reg;
   logic [RESULT_WIDTH-1:0] result_reg;
   logic [ERR_SRC_WIDTH-1:0] errSrc_reg;
   logic [IRQ_WIDTH-1:0] irqStat_reg;
   logic [IRQ_WIDTH-1:0] irqMask_reg;
   logic [6:0] panel_reg;
   logic wrPend_reg;
   logic rdPend_reg;
   logic [7:0] addr_reg;
   logic [3:0] settleCnt_reg;
   logic trigPend_reg;
   meas_state_t state_reg;
   logic trigEdge;
   logic trigAccept;
   logic panelStrobePrev_reg;
   logic panelLoad;
   logic adcDoneCmd;
   logic publishCmd;
   logic [IRQ_WIDTH-1:0] irqEvent;
   logic [JUDGE_WIDTH-1:0] judgeNext;
   logic [3:0] binExtraNext;
   logic noBinNext;
   logic subFailNext;
   logic errorNext;
   logic addrPhase;

   // ---------------------------------------------
   // Reset release
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_reg <= 1'b0;
         rst_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rst_reg <= rstMeta_reg;
      end
   end
   assign rstN = rst_reg;

   // ---------------------------------------------
   // Bus slave
   // ---------------------------------------------
   // Zero wait states: every transfer completes in its data phase
   assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         wrPend_reg <= 1'b0;
         rdPend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else begin
         wrPend_reg <= addrPhase & hwrite;
         rdPend_reg <= addrPhase & ~hwrite;
         if (addrPhase) begin
            addr_reg <= haddr;
         end
      end
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction

   assign adcDoneCmd = wrPend_reg & hit(addr_reg, STATUS_OFS) & hwdata[CMD_ADC_DONE_BIT];
   assign publishCmd = wrPend_reg & hit(addr_reg, STATUS_OFS) & hwdata[CMD_PUBLISH_BIT];

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         ctrl_reg <= CTRL_RESET;
         result_reg <= '0;
         errSrc_reg <= '0;
         irqMask_reg <= '0;
      end else if (wrPend_reg) begin
         if (hit(addr_reg, CTRL_OFS)) begin
            ctrl_reg <= {27'h0000000, hwdata[4:0]};
         end
         if (hit(addr_reg, RESULT_OFS)) begin
            result_reg <= hwdata[RESULT_WIDTH-1:0];
         end
         if (hit(addr_reg, ERRSRC_OFS)) begin
            errSrc_reg <= hwdata[ERR_SRC_WIDTH-1:0];
         end
         if (hit(addr_reg, IRQ_MASK_OFS)) begin
            irqMask_reg <= hwdata[IRQ_WIDTH-1:0];
         end
      end
   end

   // Read data registered in the address phase so hrdata comes from a flop
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         hrdata <= 32'h0000_0000;
      end else if (addrPhase & ~hwrite) begin
         unique case (1'b1)
            hit(haddr, CTRL_OFS): hrdata <= ctrl_reg;
            hit(haddr, RESULT_OFS): hrdata <= {16'h0000, result_reg};
            hit(haddr, ERRSRC_OFS): hrdata <= {27'h0000000, errSrc_reg};
            hit(haddr, STATUS_OFS): hrdata <= {28'h0000000, conversion_done_n, measure_done_n, state_reg};
            hit(haddr, IRQ_STAT_OFS): hrdata <= {29'h00000000, irqStat_reg};
            hit(haddr, IRQ_MASK_OFS): hrdata <= {29'h00000000, irqMask_reg};
            hit(haddr, PANEL_OFS): hrdata <= {25'h0000000, panel_reg};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Trigger and panel load
   // ---------------------------------------------
   edge_detect trigDet (
      .sysClk(sys_clk),
      .rstN(rstN),
      .levelIn(measure_trigger),
      .risingSel(ctrl_reg[CTRL_RISING_BIT]),
      .edgeOut(trigEdge)
   );

   // Internal trigger ignores the pin; busy triggers dropped, except while settling when enabled
   assign trigAccept = trigEdge & ctrl_reg[CTRL_EXT_MEASURE_TRIGGER_BIT]
                       & ((state_reg == IDLE_S) | ctrl_reg[CTRL_MEASURE_TRIGGER_BUSY_EN_BIT] & (state_reg == SETTLE_S));

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         panelStrobePrev_reg <= 1'b1;
         panel_reg <= 7'h00;
      end else begin
         panelStrobePrev_reg <= panel_load_strobe_n;
         if (panelLoad) begin
            panel_reg <= ~panel_sel_n;
         end
      end
   end
   assign panelLoad = panelStrobePrev_reg & ~panel_load_strobe_n;

   // ---------------------------------------------
   // Measurement sequence
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= IDLE_S;
         settleCnt_reg <= 4'h0;
         trigPend_reg <= 1'b0;
         measure_done_n <= 1'b1;
         conversion_done_n <= 1'b1;
      end else begin
         unique case (state_reg)
            IDLE_S: begin
               if (trigAccept | trigPend_reg) begin
                  state_reg <= MEASURE_S;
                  trigPend_reg <= 1'b0;
                  measure_done_n <= 1'b1;
                  conversion_done_n <= 1'b1;
               end
            end
            MEASURE_S: begin
               if (adcDoneCmd) begin
                  conversion_done_n <= 1'b0;
               end
               if (publishCmd) begin
                  state_reg <= SETTLE_S;
                  settleCnt_reg <= 4'(SETTLE_CYCLES);
               end
            end
            SETTLE_S: begin
               // Edge taken while settling is kept, so it still gets its measurement
               if (trigAccept) begin
                  trigPend_reg <= 1'b1;
               end
               // Outputs updated on entry; wait so the handler sees them stable first
               if (settleCnt_reg == 4'h0) begin
                  measure_done_n <= 1'b0;
                  conversion_done_n <= 1'b0;
                  state_reg <= IDLE_S;
               end else begin
                  settleCnt_reg <= settleCnt_reg - 4'h1;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------
   // Judgment mapping
   // ---------------------------------------------
   // Result word: [9:0] bins 1..10 or comparator bits, [10] no bin, [11] sub fail,
   // [13:12] extra bin lines, [14] panel one in, [15] panel two in
   always_comb begin
      judgeNext = '0;
      binExtraNext = '0;
      noBinNext = 1'b0;
      subFailNext = 1'b0;
      if (ctrl_reg[CTRL_CONT_MODE_BIT]) begin
         judgeNext[0] = result_reg[0];
         judgeNext[1] = result_reg[1];
         judgeNext[2] = result_reg[2];
         judgeNext[3] = result_reg[14] & result_reg[15] & ~result_reg[10];
         judgeNext[4] = result_reg[4];
         judgeNext[5] = result_reg[5];
         judgeNext[11:6] = result_reg[9:6] == 4'h0 ? 6'h00 : {2'h0, result_reg[9:6]};
      end else if (ctrl_reg[CTRL_BIN_JUDGE_BIT]) begin
         judgeNext[9:0] = result_reg[9:0];
         noBinNext = result_reg[10];
         subFailNext = result_reg[11];
      end else begin
         judgeNext[5:0] = result_reg[5:0];
      end
      binExtraNext = result_reg[13:12] == 2'h0 ? 4'h0 : {2'h0, result_reg[13:12]};
      errorNext = |errSrc_reg;
   end

   // Outputs only change when a result is published, never mid-measurement
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         judge_n <= '1;
         bin_extra_n <= 4'hf;
         no_bin_match_n <= 1'b1;
         sub_fail_n <= 1'b1;
         error_n <= 1'b1;
      end else if (publishCmd && state_reg == MEASURE_S) begin
         judge_n <= ~judgeNext;
         bin_extra_n <= ~binExtraNext;
         no_bin_match_n <= ~noBinNext;
         sub_fail_n <= ~subFailNext;
         error_n <= ~errorNext;
      end
   end

   // ---------------------------------------------
   // Interrupts
   // ---------------------------------------------
   assign irqEvent = {measure_done_n == 1'b1 && state_reg == SETTLE_S && settleCnt_reg == 4'h0,
                      panelLoad, trigAccept};

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         irqStat_reg <= '0;
         irq <= 1'b0;
      end else begin
         // Set wins over a write-one clear in the same cycle
         irqStat_reg <= (irqStat_reg & ~((wrPend_reg & hit(addr_reg, IRQ_STAT_OFS))
                         ? hwdata[IRQ_WIDTH-1:0] : {IRQ_WIDTH{1'b0}})) | irqEvent;
         irq <= |(irqStat_reg & irqMask_reg);
      end
   end
endmodule
